// File: core/tmc_pkg.sv
// constants, field layouts and carrier types for the eight-bit timer/counter
package tmc_pkg;

  // ----------------------------------------------------------------
  // register byte offsets on the register bus
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_OPTION = 8'h00;  // timer_option_control
  localparam logic [7:0] OFS_INTERRUPT_CONTROL = 8'h04;  // interrupt_control
  localparam logic [7:0] OFS_COUNT  = 8'h08;  // timer_count
  localparam logic [7:0] OFS_STATUS = 8'h0c;  // sticky event status, read only
  localparam logic [7:0] OFS_CLEAR  = 8'h10;  // event clear, write only
  localparam logic [7:0] OFS_ENABLE = 8'h14;  // event enable

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int OPT_PULLUP_DIS = 7;  // pullup_global_disable
  localparam int OPT_EXT_EDGE   = 6;  // ext_irq_edge_select
  localparam int OPT_CS         = 5;  // count_source_select
  localparam int OPT_SE         = 4;  // source_edge_select
  localparam int OPT_BYPASS     = 3;  // prescaler_bypass
  localparam int OPT_RATE_LSB   = 0;  // prescale_rate, three bits
  localparam int INT_GIE        = 7;  // global_irq_enable
  localparam int INT_OVF_IE     = 5;  // overflow_irq_enable
  localparam int INT_EXT_IE     = 4;  // external pin interrupt enable
  localparam int INT_OVF_FLAG   = 2;  // overflow_flag
  localparam int INT_EXT_FLAG   = 1;  // external pin interrupt flag
  localparam int EVT_OVF        = 0;  // status bit: count overflow
  localparam int EVT_EXT        = 1;  // status bit: external pin edge

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] OPTION_RST = 8'hff;
  localparam logic [7:0] INTERRUPT_CONTROL_RST = 8'h00;
  localparam logic [7:0] COUNT_RST  = 8'h00;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int         CLK_PERIOD_NS  = 10;
  localparam int         INSTR_CYCLE_NS = 40;  // four oscillator periods
  localparam int         CLKS_PER_INSTR = INSTR_CYCLE_NS / CLK_PERIOD_NS;
  localparam int         INHIBIT_INSTR  = 2;
  localparam logic [3:0] INHIBIT_CLKS   = 4'(INHIBIT_INSTR * CLKS_PER_INSTR);

  // ----------------------------------------------------------------
  // bus answers
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // instruction cycle phases
  typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} tmc_phase_t;

  // register bus, master to slave
  typedef struct packed {
    logic [7:0]  awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [7:0]  araddr;
    logic        arvalid;
    logic        rready;
  } tmc_axi_req_t;

  // register bus, slave to master
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } tmc_axi_resp_t;

  // all state of the block
  typedef struct packed {
    tmc_phase_t  phase;
    logic [7:0]  option;
    logic [7:0]  interrupt_control;
    logic [7:0]  count;
    logic [7:0]  pre;
    logic [3:0]  inhib;
    logic        pre_samp;
    logic        ext_prev;
    logic        irq_pin_prev;
    logic [1:0]  status;
    logic [1:0]  irq_en;
    logic        aw_held;
    logic [7:0]  aw_addr;
    logic        w_held;
    logic [7:0]  wdata;
    logic        wstrb0;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } tmc_state_t;

endpackage

// File: core/tmc_timer.sv
// eight-bit timer/counter with prescaler, option register and register bus slave
//
// Local design decisions: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// [R1] internal clock, prescaler bypassed: count advances once every instruction cycle
// [R2] source select bit 5: 1 external input edges, 0 instruction cycle clock
// [R3] count increments are held off for two instruction cycles after a count write
// [R4] software may preload a compensated count to cover the two lost cycles
// [R5] counter mode (source select 1) counts external input edges
// [R6] edge select bit 4: 1 counts falling edges, 0 counts rising edges
// [R7] counter mode samples prescaler output in phases two and four
// [R8] bypass bit 3: 0 routes source through prescaler, 1 gives rate 1:1
// [R9] three-bit rate field divides by two to the power field plus one
// [R10] prescaler is private to this timer and not visible to software
// [R11] every count write clears the prescaler
// [R12] wrap from ff to 00 sets overflow flag regardless of its enable
// [R13] hardware never clears the overflow flag; software clears it by writing
// [R14] overflow enable bit 5 gates overflow flag bit 2 onto the interrupt
// [R15] during sleep the count holds and no overflow can occur
// [R16] global pull-up disable turns off all pull-ups except master clear
// [R17] external interrupt edge select: 1 rising, 0 falling
// [R18] interrupt request high while flag, its enable and global enable are set
module tmc_timer
  import tmc_pkg::*;
(
  input  wire logic          CLK_SYS_I,
  input  wire logic          RST_I,
  input  wire logic          CE_I,
  input  wire logic          SLEEP_I,
  input  wire logic          EXT_COUNT_I,
  input  wire logic          EXT_IRQ_PIN_I,
  input  wire logic [7:0]    PER_PIN_PULLUP_I,
  input  wire logic          MASTER_CLEAR_PULLUP_I,
  input  wire tmc_axi_req_t  AXI_REQ_I,
  output var  tmc_axi_resp_t AXI_RESP_O,
  output logic [7:0]         PULLUP_EN_O,
  output logic               MASTER_CLEAR_PULLUP_EN_O,
  output logic               IRQ_O
);

  tmc_state_t st;
  tmc_state_t next_st;

  // ----------------------------------------------------------------
  // bus handshakes and write decode
  // ----------------------------------------------------------------
  logic       aw_hs;
  logic       w_hs;
  logic       ar_hs;
  logic       wr_fire;
  logic       wr_mapped;
  logic       wr_en;
  logic       count_wr;
  logic       interrupt_control_wr;
  logic       rd_mapped;
  logic [7:0] rd_value;

  // readies are combinational; one write and one read in flight
  always_comb begin
    AXI_RESP_O         = '0;
    AXI_RESP_O.awready = ~st.aw_held & ~st.bvalid;
    AXI_RESP_O.wready  = ~st.w_held & ~st.bvalid;
    AXI_RESP_O.bvalid  = st.bvalid;
    AXI_RESP_O.bresp   = st.bresp;
    AXI_RESP_O.arready = ~st.rvalid;
    AXI_RESP_O.rvalid  = st.rvalid;
    AXI_RESP_O.rdata   = st.rdata;
    AXI_RESP_O.rresp   = st.rresp;
  end

  assign aw_hs     = AXI_REQ_I.awvalid & AXI_RESP_O.awready;
  assign w_hs      = AXI_REQ_I.wvalid & AXI_RESP_O.wready;
  assign ar_hs     = AXI_REQ_I.arvalid & AXI_RESP_O.arready;
  assign wr_fire   = st.aw_held & st.w_held & ~st.bvalid;
  assign wr_mapped = (st.aw_addr == OFS_OPTION) | (st.aw_addr == OFS_INTERRUPT_CONTROL) | (st.aw_addr == OFS_COUNT)
                   | (st.aw_addr == OFS_CLEAR) | (st.aw_addr == OFS_ENABLE);
  assign wr_en     = wr_fire & wr_mapped & st.wstrb0;
  assign count_wr  = wr_en & (st.aw_addr == OFS_COUNT);
  assign interrupt_control_wr = wr_en & (st.aw_addr == OFS_INTERRUPT_CONTROL);

  // read mux; status is read only, clear reads as zero
  always_comb begin
    rd_mapped = 1'b1;
    rd_value  = 8'h00;
    case (AXI_REQ_I.araddr)
      OFS_OPTION: rd_value = st.option;
      OFS_INTERRUPT_CONTROL: rd_value = st.interrupt_control;
      OFS_COUNT:  rd_value = st.count;
      OFS_STATUS: rd_value = {6'h00, st.status};
      OFS_CLEAR:  rd_value = 8'h00;
      OFS_ENABLE: rd_value = {6'h00, st.irq_en};
      default:    rd_mapped = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // count source, prescaler and synchronisation
  // ----------------------------------------------------------------
  logic       opt_cs;
  logic       opt_bypass;
  logic [2:0] opt_rate;
  logic       run;
  logic       ext_lvl;
  logic       ext_edge;
  logic       instr_tick;
  logic       src_tick;
  logic       pre_out;
  logic       samp_now;
  logic       samp_rise;
  logic       inc_raw;
  logic       inc;
  logic       ovf;
  logic       irq_lvl;
  logic       irq_edge;

  assign opt_cs     = st.option[OPT_CS];
  assign opt_bypass = st.option[OPT_BYPASS];
  assign opt_rate   = st.option[OPT_RATE_LSB +: 3];
  assign run        = ~SLEEP_I;                                   // R15
  // inverting the pin makes the falling edge look like a rising one
  assign ext_lvl    = EXT_COUNT_I ^ st.option[OPT_SE];            // R6
  assign ext_edge   = ext_lvl & ~st.ext_prev;
  assign instr_tick = (st.phase == PH_Q4);
  assign src_tick   = opt_cs ? ext_edge : instr_tick;             // R2 R5
  // prescaler bit n toggles every 2^n ticks, so its rise is one per 2^(n+1)
  assign pre_out    = opt_bypass ? ext_lvl : st.pre[opt_rate];    // R8 R9
  assign samp_now   = (st.phase == PH_Q2) | (st.phase == PH_Q4);  // R7
  assign samp_rise  = samp_now & pre_out & ~st.pre_samp;
  assign inc_raw    = (~opt_cs & opt_bypass) ? instr_tick : samp_rise;  // R1
  assign inc        = run & inc_raw & (st.inhib == 4'h0) & ~count_wr;   // R3
  assign ovf        = inc & (st.count == 8'hff);
  // external interrupt pin edge, same inversion trick
  assign irq_lvl    = EXT_IRQ_PIN_I ^ ~st.option[OPT_EXT_EDGE];   // R17
  assign irq_edge   = irq_lvl & ~st.irq_pin_prev;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st              = st;
    next_st.irq_pin_prev = irq_lvl;
    // instruction clock, prescaler and count stop while asleep
    if (run) begin
      case (st.phase)
        PH_Q1:   next_st.phase = PH_Q2;
        PH_Q2:   next_st.phase = PH_Q3;
        PH_Q3:   next_st.phase = PH_Q4;
        default: next_st.phase = PH_Q1;
      endcase
      next_st.ext_prev = ext_lvl;
      if (samp_now) begin
        next_st.pre_samp = pre_out;
      end
      if (src_tick & ~opt_bypass) begin
        next_st.pre = st.pre + 8'h01;                         // R10
      end
      if (st.inhib != 4'h0) begin
        next_st.inhib = st.inhib - 4'h1;
      end
      if (inc) begin
        next_st.count = st.count + 8'h01;
      end
    end
    // bus address and data capture, either order
    if (aw_hs) begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = AXI_REQ_I.awaddr;
    end
    if (w_hs) begin
      next_st.w_held = 1'b1;
      next_st.wdata  = AXI_REQ_I.wdata[7:0];
      next_st.wstrb0 = AXI_REQ_I.wstrb[0];
    end
    // register write once both halves are held
    if (wr_fire) begin
      next_st.aw_held = 1'b0;
      next_st.w_held  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end
    if (wr_en) begin
      case (st.aw_addr)
        OFS_OPTION: next_st.option = st.wdata;
        OFS_INTERRUPT_CONTROL: next_st.interrupt_control = st.wdata;              // R13
        OFS_COUNT: begin
          next_st.count = st.wdata;
          next_st.pre   = 8'h00;                            // R11
          next_st.inhib = INHIBIT_CLKS;                     // R3
        end
        OFS_CLEAR:  next_st.status = st.status & ~st.wdata[1:0];
        OFS_ENABLE: next_st.irq_en = st.wdata[1:0];
        default:    next_st.bresp  = RESP_SLVERR;
      endcase
    end
    // hardware sets win over software clears
    if (ovf) begin
      next_st.interrupt_control[INT_OVF_FLAG] = 1'b1;                  // R12
      next_st.status[EVT_OVF]      = 1'b1;
    end
    if (irq_edge) begin
      next_st.interrupt_control[INT_EXT_FLAG] = 1'b1;
      next_st.status[EVT_EXT]      = 1'b1;
    end
    if (st.bvalid & AXI_REQ_I.bready) begin
      next_st.bvalid = 1'b0;
    end
    // read answer registered one cycle after the address is taken
    if (st.rvalid & AXI_REQ_I.rready) begin
      next_st.rvalid = 1'b0;
    end
    if (ar_hs) begin
      next_st.rvalid = 1'b1;
      next_st.rdata  = {24'h000000, rd_value};
      next_st.rresp  = rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      st        <= '0;
      st.option <= OPTION_RST;
      st.interrupt_control <= INTERRUPT_CONTROL_RST;
      st.count  <= COUNT_RST;
      st.ext_prev <= OPTION_RST[OPT_SE];  // a low pin seen through the reset edge select
      st.pre_samp <= OPTION_RST[OPT_SE];  // no false rise on the first sampling phase
    end else if (CE_I) begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // pins and interrupt
  // ----------------------------------------------------------------
  // master clear pull-up always follows its own latch
  assign PULLUP_EN_O              = st.option[OPT_PULLUP_DIS] ? 8'h00 : PER_PIN_PULLUP_I;  // R16
  assign MASTER_CLEAR_PULLUP_EN_O = MASTER_CLEAR_PULLUP_I;
  assign IRQ_O = (st.interrupt_control[INT_GIE] & st.interrupt_control[INT_OVF_IE] & st.interrupt_control[INT_OVF_FLAG])  // R14 R18
               | (st.interrupt_control[INT_GIE] & st.interrupt_control[INT_EXT_IE] & st.interrupt_control[INT_EXT_FLAG])
               | (|(st.status & st.irq_en));

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (RST_I);

  property p_bypass_step;
    CE_I && run && !opt_cs && opt_bypass && st.inhib == 4'h0 && !count_wr && st.phase == PH_Q4
      |=> st.count == 8'($past(st.count) + 8'h01);
  endproperty
  a_bypass_step: assert property (p_bypass_step) else $error("count missed an instruction cycle step"); // R1

  property p_inhibit_load;
    CE_I && count_wr |=> st.inhib == INHIBIT_CLKS && st.pre == 8'h00 && st.count == $past(st.wdata);
  endproperty
  a_inhibit_load: assert property (p_inhibit_load) else $error("count write did not load and pause"); // R11

  property p_inhibit_hold;
    st.inhib != 4'h0 && !count_wr |=> st.count == $past(st.count);
  endproperty
  a_inhibit_hold: assert property (p_inhibit_hold) else $error("count moved during post-write pause"); // R3

  property p_sleep_hold;
    SLEEP_I && !count_wr |=> $stable(st.count) && $stable(st.pre);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("timer moved during sleep"); // R15

  property p_overflow_set;
    CE_I && inc && st.count == 8'hff |=> st.interrupt_control[INT_OVF_FLAG] && st.count == 8'h00;
  endproperty
  a_overflow_set: assert property (p_overflow_set) else $error("wrap did not set overflow flag"); // R12

  property p_flag_sticky;
    st.interrupt_control[INT_OVF_FLAG] && !(interrupt_control_wr && !st.wdata[INT_OVF_FLAG]) |=> st.interrupt_control[INT_OVF_FLAG];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("overflow flag cleared without software"); // R13

  property p_irq_level;
    st.interrupt_control[INT_GIE] && st.interrupt_control[INT_OVF_IE] && st.interrupt_control[INT_OVF_FLAG] |-> IRQ_O;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt low with enabled overflow"); // R18

  property p_pullup_off;
    st.option[OPT_PULLUP_DIS] |-> PULLUP_EN_O == 8'h00 && MASTER_CLEAR_PULLUP_EN_O == MASTER_CLEAR_PULLUP_I;
  endproperty
  a_pullup_off: assert property (p_pullup_off) else $error("pull-up active under global disable"); // R16

  property p_ext_edge;
    CE_I && st.option[OPT_EXT_EDGE] && EXT_IRQ_PIN_I && !st.irq_pin_prev |=> st.status[EVT_EXT];
  endproperty
  a_ext_edge: assert property (p_ext_edge) else $error("rising pin edge not flagged"); // R17

  property p_ext_fall;
    CE_I && !st.option[OPT_EXT_EDGE] && !EXT_IRQ_PIN_I && !st.irq_pin_prev |=> st.status[EVT_EXT];
  endproperty
  a_ext_fall: assert property (p_ext_fall) else $error("falling pin edge not flagged"); // R17

  property p_count_step;
    !count_wr |=> st.count == $past(st.count) || st.count == 8'($past(st.count) + 8'h01);
  endproperty
  a_count_step: assert property (p_count_step) else $error("count moved by more than one"); // R1

  property p_timer_phase;
    !count_wr && !opt_cs && opt_bypass && st.phase != PH_Q4 |=> $stable(st.count);
  endproperty
  a_timer_phase: assert property (p_timer_phase) else $error("timer stepped outside phase four"); // R2

  property p_sample_phase;
    !count_wr && (opt_cs || !opt_bypass) && !samp_now |=> $stable(st.count);
  endproperty
  a_sample_phase: assert property (p_sample_phase) else $error("count stepped outside a sampling phase"); // R7

  property p_pre_step;
    CE_I && run && src_tick && !opt_bypass && !count_wr |=> st.pre == 8'($past(st.pre) + 8'h01);
  endproperty
  a_pre_step: assert property (p_pre_step) else $error("prescaler missed a source tick"); // R9

  property p_pre_bypass;
    opt_bypass && !count_wr |=> $stable(st.pre);
  endproperty
  a_pre_bypass: assert property (p_pre_bypass) else $error("bypassed prescaler moved"); // R8

  property p_status_set;
    CE_I && ovf |=> st.status[EVT_OVF];
  endproperty
  a_status_set: assert property (p_status_set) else $error("wrap did not set overflow status"); // R12

  property p_sleep_phase;
    SLEEP_I && !count_wr |=> $stable(st.phase) && $stable(st.inhib);
  endproperty
  a_sleep_phase: assert property (p_sleep_phase) else $error("instruction clock ran during sleep"); // R15

  property p_irq_idle;
    !st.interrupt_control[INT_GIE] && !(|(st.status & st.irq_en)) |-> !IRQ_O;
  endproperty
  a_irq_idle: assert property (p_irq_idle) else $error("interrupt high with global enable off"); // R14

endmodule // tmc_timer

`default_nettype wire

// File: sim/tmc_pin_model.sv
// model of the outside circuit that drives the external count input pin
`timescale 1ns/1ns
`default_nettype none

module tmc_pin_model (
  input  wire logic       clk_i,
  input  wire logic       go_i,
  input  wire logic [7:0] toggles_i,
  output logic            pin_o,
  output logic            busy_o
);
  logic [7:0] left  = 8'h00;
  logic [2:0] tick  = 3'h0;
  logic       level = 1'b0;  // the pin idles low and keeps its level between bursts

  // ---------------------------------------------------------------
  // burst of toggles, one every eight clocks
  // ---------------------------------------------------------------
  // each level outlasts a full instruction cycle so both sampling phases see it
  always @(posedge clk_i) begin
    if (go_i) begin
      left <= toggles_i;
      tick <= 3'h0;
    end else if (left != 8'h00) begin
      tick <= tick + 3'h1;
      if (tick == 3'h7) begin
        level <= ~level;
        left  <= left - 8'h01;
      end
    end
  end

  // busy while toggles remain
  assign busy_o = (left != 8'h00);
  assign pin_o  = level;
endmodule // tmc_pin_model

`default_nettype wire

// File: sim/eight_bit_timer_counter_tb_top.sv
// register-level testbench for the eight-bit timer/counter
`timescale 1ns/1ns
`default_nettype none

module eight_bit_timer_counter_tb_top;
  import tmc_pkg::*;
  logic          clk, rst, ce, sleep, ext_irq, go, pin, busy, mc_pu, mc_en, irq;
  logic [7:0]    pu_lat, tgl, pu_en;
  tmc_axi_req_t  req;
  tmc_axi_resp_t rsp;
  logic [31:0]   rdat;
  int            n_errors, n_compared, wr_cyc, rd_cyc, r;
  int            cyc = 0;

  tmc_timer i_tmc_timer (.CLK_SYS_I(clk), .RST_I(rst), .CE_I(ce), .SLEEP_I(sleep), .EXT_COUNT_I(pin),
    .EXT_IRQ_PIN_I(ext_irq), .PER_PIN_PULLUP_I(pu_lat), .MASTER_CLEAR_PULLUP_I(mc_pu), .AXI_REQ_I(req),
    .AXI_RESP_O(rsp), .PULLUP_EN_O(pu_en), .MASTER_CLEAR_PULLUP_EN_O(mc_en), .IRQ_O(irq));
  tmc_pin_model i_tmc_pin_model (.clk_i(clk), .go_i(go), .toggles_i(tgl), .pin_o(pin), .busy_o(busy));

  // ---------------------------------------------------------------
  // clock and cycle count
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;

  // ---------------------------------------------------------------
  // reporting
  // ---------------------------------------------------------------
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // a count whose phase is not pinned down may be one off either way
  task automatic chk_rng(input string nm, input int e, input logic [31:0] got);
    n_compared++;
    if (!((got >= 32'(e > 0 ? e - 1 : 0)) === 1'b1 && (got <= 32'(e + 1)) === 1'b1)) begin
      n_errors++;
      $display("BAD %s expected %0d seen %h", nm, e, got);
    end
  endtask

  task automatic hang(input string nm);
    n_errors++;
    $display("BAD %s expected answer seen none", nm);
    print_verdict();
  endtask

  task automatic end_test(input string nm);
    $display("test %s done", nm);
  endtask

  // ---------------------------------------------------------------
  // register bus master
  // ---------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int i;
    @(posedge clk);
    req <= '{awaddr: a, awvalid: 1'b1, wdata: {24'h0, d}, wstrb: 4'hf, wvalid: 1'b1, bready: 1'b1,
             araddr: req.araddr, arvalid: 1'b0, rready: 1'b0};
    for (i = 0; i < 100; i++) begin
      @(posedge clk);
      if (req.awvalid && rsp.awready === 1'b1) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready === 1'b1) req.wvalid <= 1'b0;
      if (rsp.bvalid === 1'b1) break;
    end
    if (i == 100) hang("write answer");
    wr_cyc = cyc;
    req.bready <= 1'b0;
    chk("write response", {30'h0, er}, {30'h0, rsp.bresp});
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] er);
    int i;
    @(posedge clk);
    req.araddr  <= a;
    req.arvalid <= 1'b1;
    req.rready  <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge clk);
      if (req.arvalid && rsp.arready === 1'b1) req.arvalid <= 1'b0;
      if (rsp.rvalid === 1'b1) break;
    end
    if (i == 100) hang("read answer");
    rd_cyc = cyc;
    rdat = rsp.rdata;
    req.rready <= 1'b0;
    chk("read response", {30'h0, er}, {30'h0, rsp.rresp});
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string nm);
    rd(a, RESP_OKAY);
    chk(nm, {24'h0, exp}, rdat);
  endtask

  // ---------------------------------------------------------------
  // timer scenarios
  // ---------------------------------------------------------------
  // count from zero for a while; the pause of eight clocks is taken off
  task automatic measure(input logic [7:0] opt, input int clks, input int div, input string nm);
    wr(OFS_OPTION, opt, RESP_OKAY);
    wr(OFS_COUNT, 8'h00, RESP_OKAY);
    repeat (clks) @(posedge clk);
    rd(OFS_COUNT, RESP_OKAY);
    chk_rng(nm, (rd_cyc - wr_cyc - 8) / div, rdat);
  endtask

  // preload the count, then let the pin model toggle k times
  task automatic extc(input logic [7:0] opt, input logic [7:0] c0, input logic [7:0] k,
                      input logic [7:0] exp, input string nm);
    int i;
    wr(OFS_OPTION, opt, RESP_OKAY);
    wr(OFS_COUNT, c0, RESP_OKAY);
    repeat (12) @(posedge clk);
    tgl <= k;
    go  <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    for (i = 0; i < 300; i++) begin
      @(posedge clk);
      if (busy === 1'b0) break;
    end
    if (i == 300) hang("pin model");
    repeat (8) @(posedge clk);
    rdc(OFS_COUNT, exp, nm);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    sleep = 1'b0;
    ext_irq = 1'b0;
    go = 1'b0;
    tgl = 8'h00;
    pu_lat = 8'h5a;
    mc_pu = 1'b1;
    req = '0;
    n_errors = 0;
    n_compared = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rdc(OFS_OPTION, OPTION_RST, "option reset");
    rdc(OFS_INTERRUPT_CONTROL, INTERRUPT_CONTROL_RST, "interrupt_control reset");
    rdc(OFS_COUNT, COUNT_RST, "count reset");
    rdc(OFS_STATUS, 8'h00, "status reset");
    chk("pullups off", 32'h0, {24'h0, pu_en});
    chk("master clear pullup", 32'h1, {31'h0, mc_en});
    rd(8'h18, RESP_SLVERR);
    chk("unmapped read data", 32'h0, rdat);
    wr(OFS_STATUS, 8'h01, RESP_SLVERR);
    end_test("reset");
    measure(8'h08, 40, 4, "timer bypass");
    chk("pullups per pin", {24'h0, pu_lat}, {24'h0, pu_en});
    for (r = 0; r < 8; r++) begin
      measure(8'(r), 16 << (r + 1), 4 << (r + 1), "prescaled");
    end
    end_test("timer");
    extc(8'h28, 8'h00, 8'd5, 8'd3, "rising edges");
    extc(8'h38, 8'h00, 8'd5, 8'd3, "falling edges");
    extc(8'h20, 8'h00, 8'd4, 8'd1, "prescaled edges");
    end_test("counter");
    // rise then fall under each interrupt edge select, rising select first
    for (r = 0; r < 4; r++) begin
      wr(OFS_OPTION, (r < 2) ? 8'h48 : 8'h08, RESP_OKAY);
      wr(OFS_INTERRUPT_CONTROL, 8'h00, RESP_OKAY);
      ext_irq <= ~r[0];
      repeat (4) @(posedge clk);
      rdc(OFS_INTERRUPT_CONTROL, {6'h0, (r < 2) == ~r[0], 1'b0}, "pin edge flag");
    end
    end_test("pin edge");
    wr(OFS_CLEAR, 8'h03, RESP_OKAY);
    wr(OFS_INTERRUPT_CONTROL, 8'h00, RESP_OKAY);
    extc(8'h28, 8'hff, 8'd1, 8'h00, "wrap");
    rdc(OFS_INTERRUPT_CONTROL, 8'h04, "overflow flag");
    chk("irq disabled", 32'h0, {31'h0, irq});
    rdc(OFS_STATUS, 8'h01, "overflow status");
    wr(OFS_INTERRUPT_CONTROL, 8'ha4, RESP_OKAY);
    chk("irq enabled", 32'h1, {31'h0, irq});
    wr(OFS_INTERRUPT_CONTROL, 8'h84, RESP_OKAY);
    chk("irq gated", 32'h0, {31'h0, irq});
    repeat (20) @(posedge clk);
    rdc(OFS_INTERRUPT_CONTROL, 8'h84, "flag kept");
    wr(OFS_INTERRUPT_CONTROL, 8'h80, RESP_OKAY);
    wr(OFS_ENABLE, 8'h01, RESP_OKAY);
    chk("status irq", 32'h1, {31'h0, irq});
    wr(OFS_CLEAR, 8'h01, RESP_OKAY);
    rdc(OFS_STATUS, 8'h00, "status cleared");
    chk("status irq off", 32'h0, {31'h0, irq});
    end_test("overflow");
    wr(OFS_OPTION, 8'h08, RESP_OKAY);
    wr(OFS_COUNT, 8'h40, RESP_OKAY);
    sleep <= 1'b1;
    repeat (40) @(posedge clk);
    rdc(OFS_COUNT, 8'h40, "sleep hold");
    ce    <= 1'b0;
    sleep <= 1'b0;
    repeat (40) @(posedge clk);
    ce <= 1'b1;
    rdc(OFS_COUNT, 8'h40, "clock enable hold");
    end_test("sleep");
    print_verdict();
  end
endmodule // eight_bit_timer_counter_tb_top

`default_nettype wire
